// ---- hw/rsic_cause.sv ----
// Purpose: Reset cause status register, clear on read
// Assumes: rst_b is the power-on reset only
// Notes:   A source active in the read cycle survives the clear
`default_nettype none
`include "rsic_params.svh"

module rsic_cause
  import rsic_pkg::*;
(
  // Clock and power-on reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Core side
  rsic_if.cause_side cif
);

  rsic_cause_t r;
  rsic_cause_t next_r;

  // Accumulate sources, read clears all, set wins
  always_comb begin
    next_r = r;
    if (cif.cause_rd) begin
      next_r.cause = 8'h00;
    end
    next_r.cause[6:1] = next_r.cause[6:1] | cif.cause_src;
  end

  // Power-on sets only the power-on flag
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r.cause <= `RSIC_CAUSE_POR_VAL;
    end else begin
      r <= next_r;
    end
  end

  assign cif.cause = r.cause;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_cause_read_clear: assert property (cif.cause_rd && cif.cause_src == 6'h00 |=> r.cause == 8'h00)
    else $error("cause register not cleared by read");
  a_pin_flag_set: assert property (cif.cause_src[`RSIC_CAUSE_PIN] |=> r.cause[`RSIC_CAUSE_PIN])
    else $error("pin reset flag not set");
  a_lowv_flag_set: assert property (cif.cause_src[`RSIC_CAUSE_LOWV] |=> r.cause[`RSIC_CAUSE_LOWV])
    else $error("low supply flag not set");

endmodule : rsic_cause
`default_nettype wire

// ---- hw/rsic_prio.sv ----
// Purpose: Fixed priority resolver, group 1 highest, 16 lowest
// Assumes: Requests already gated by their enables
// Notes:   Purely combinational
`default_nettype none
`include "rsic_params.svh"

module rsic_prio
  import rsic_pkg::*;
(
  // Core side
  rsic_if.prio pif
);

  // Vector of the highest-priority pending group
  function automatic logic [15:0] rsic_pick(input logic [16:1] req);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 16; i >= 1; i--) begin
      if (req[i]) begin
        idx = 5'(i);
      end
    end
    case (idx)
      5'h01:   rsic_pick = `RSIC_VEC_G1;
      5'h02:   rsic_pick = `RSIC_VEC_G2;
      5'h03:   rsic_pick = `RSIC_VEC_G3;
      5'h04:   rsic_pick = `RSIC_VEC_G4;
      5'h05:   rsic_pick = `RSIC_VEC_G5;
      5'h06:   rsic_pick = `RSIC_VEC_G6;
      5'h08:   rsic_pick = `RSIC_VEC_G8;
      5'h09:   rsic_pick = `RSIC_VEC_G9;
      5'h0a:   rsic_pick = `RSIC_VEC_G10;
      5'h0b:   rsic_pick = `RSIC_VEC_G11;
      5'h0c:   rsic_pick = `RSIC_VEC_G12;
      5'h0d:   rsic_pick = `RSIC_VEC_G13;
      5'h0e:   rsic_pick = `RSIC_VEC_G14;
      5'h0f:   rsic_pick = `RSIC_VEC_G15;
      5'h10:   rsic_pick = `RSIC_VEC_G16;
      default: rsic_pick = `RSIC_VEC_SWI;
    endcase
  endfunction : rsic_pick

  // Resolve
  assign pif.grp_vec = rsic_pick(pif.grp_req);
  assign pif.grp_any = |pif.grp_req;

endmodule : rsic_prio
`default_nettype wire

// ---- hw/rsic_top.sv ----
// Purpose: Reset cause capture and interrupt arbitration for an 8-bit MCU
// Assumes: rst_b is power-on reset; later resets arrive as source levels
// Notes:   CPU signals share sys_clk; pins pass two flip-flops
//
// Overview of operation
// - Reset pin reset sets external-reset flag; power-on or read clears it.
// - Watchdog timeout reset sets watchdog flag; power-on or read clears it.
// - Illegal opcode reset sets bad-opcode flag; power-on or read clears it.
// - Opcode fetch from unmapped address sets its flag; power-on or read clears.
// - Monitor mode entry reset sets monitor flag; power-on or read clears it.
// - Low supply reset sets low-supply flag; power-on or read clears it.
// - Reading the cause register clears all flags; flags accumulate until then.
// - Power-on sets power-on flag and clears all other cause flags.
// - Interrupt entry waits for the current instruction to finish.
// - Entry pushes CPU registers; return-from-interrupt pops them back.
// - Entry sets the global mask; a latched interrupt cannot be preempted.
// - Upper index byte is never stacked.
// - At each boundary with mask clear, highest-priority pending request wins.
// - Request pending at return is taken before the next main instruction.
// - Priorities 0 to 16 fixed; each group but reserved 7 has a two-byte vector, 14 and 15 sharing ffde.
// - Global mask blocks every source except the software interrupt.
// - Software interrupt is unmaskable, stacks PC; hardware stacks PC minus one.
// - Each PLL lock change sets PLL flag; request only with its enable.
// - Timer wrap at modulo sets overflow flag; request only with enable.
// - Capture or compare sets channel flag; request only with its enable.
// - Serial rx-full and tx-empty flags set on transfers, each own enable.
// - Mode-fault flag on slave select fault when detection is enabled.
// - Overrun flag when a byte arrives before previous one was read.
`default_nettype none
`include "rsic_params.svh"

module rsic_top
  import rsic_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Reset sources from system reset logic
  input  wire logic        rst_pin_b,
  input  wire logic        rst_src_wdog,
  input  wire logic        rst_src_opcode,
  input  wire logic        rst_src_fetch,
  input  wire logic        rst_src_monitor,
  input  wire logic        rst_src_lowv,
  // CPU core handshake
  input  wire logic        cpu_insn_done,
  input  wire logic        cpu_i_mask,
  input  wire logic        cpu_swi_exec,
  input  wire logic        cpu_rti_exec,
  output logic             stack_push,
  output logic             stack_pop,
  output logic      [2:0]  stack_sel,
  output logic             stack_pc_minus_one,
  output logic             vector_load,
  output logic      [15:0] vector_addr,
  output logic             set_i_mask,
  output logic             cpu_hold,
  // Peripheral events and pins
  input  wire logic        external_interrupt_pin,
  input  wire logic        pll_locked,
  input  wire logic        tim1_wrap,
  input  wire logic [1:0]  tim1_chan_evt,
  input  wire logic        tim2_wrap,
  input  wire logic        tim2_chan_evt,
  input  wire logic        spi_rx_xfer,
  input  wire logic        spi_tx_xfer,
  input  wire logic        spi_rx_read,
  input  wire logic        spi_master,
  input  wire logic        spi_busy,
  input  wire logic        spi_select_pin,
  input  wire logic [5:0]  ext_grp_req
);

  // --------------------------------------------------------------------
  // State and submodules
  // --------------------------------------------------------------------
  rsic_core_t            r;
  rsic_core_t            next_r;
  logic [`RSIC_NFLAG-1:0] set_v;
  logic [`RSIC_NFLAG-1:0] clr_v;
  logic [`RSIC_NFLAG-1:0] gate_v;
  logic [`RSIC_NFLAG-1:0] fe;
  logic                  boundary;
  logic                  ss_rise;

  rsic_if cif ();

  rsic_cause u_cause (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .cif     (cif.cause_side)
  );

  rsic_prio u_prio (
    .pif (cif.prio)
  );

  // --------------------------------------------------------------------
  // Reset cause sources and clear-on-read
  // --------------------------------------------------------------------
  assign cif.cause_src = {~r.s2[2], rst_src_wdog, rst_src_opcode,
                          rst_src_fetch, rst_src_monitor, rst_src_lowv};
  assign cif.cause_rd  = reg_rd && (reg_addr == `RSIC_ADDR_CAUSE);

  // --------------------------------------------------------------------
  // Request gating
  // --------------------------------------------------------------------
  // Error enable serves both overrun and mode fault
  assign gate_v = {r.en[10], r.en[`RSIC_F_OVR], r.en[8:1], ~r.en[`RSIC_F_EXT]};
  assign fe     = r.flags & gate_v;
  // Group 7 is reserved and never requests
  assign cif.grp_req = {ext_grp_req, fe[10], fe[9] | fe[8] | fe[7], fe[6], 1'b0,
                        fe[5:0]};

  // Slave select rising edge on the synchronised pin
  assign ss_rise  = r.s2[1] && !r.ss_prev;
  // Instruction boundary, or the recheck right after a return
  assign boundary = cpu_insn_done || r.pend;

  // --------------------------------------------------------------------
  // Flag set and clear terms
  // --------------------------------------------------------------------
  always_comb begin
    set_v = '0;
    clr_v = '0;
    set_v[`RSIC_F_EXT]   = ~r.s2[0];
    set_v[`RSIC_F_PLL]   = pll_locked ^ r.pll_prev;
    set_v[3:2]           = tim1_chan_evt;
    set_v[`RSIC_F_T1OV]  = tim1_wrap;
    set_v[5]             = tim2_chan_evt;
    set_v[6]             = tim2_wrap;
    set_v[`RSIC_F_RX]    = spi_rx_xfer;
    set_v[10]            = spi_tx_xfer;
    set_v[`RSIC_F_OVR]   = spi_rx_xfer && r.flags[`RSIC_F_RX] && !spi_rx_read;
    set_v[`RSIC_F_FAULT] = r.en[`RSIC_E_FDEN] &&
                           ((!spi_master && spi_busy && ss_rise) ||
                            (spi_master && !r.s2[1]));
    // Software clears by writing ones
    if (reg_wr && reg_addr == `RSIC_ADDR_FLAG_LO) begin
      clr_v[7:0] = reg_wdata;
    end
    if (reg_wr && reg_addr == `RSIC_ADDR_FLAG_HI) begin
      clr_v[10:8] = reg_wdata[2:0];
    end
    // Reading the receive buffer empties it
    if (spi_rx_read) begin
      clr_v[`RSIC_F_RX] = 1'b1;
    end
    // External request acknowledged on its own vector fetch
    if (r.st == RSIC_VECT && r.vec == `RSIC_VEC_G1) begin
      clr_v[`RSIC_F_EXT] = 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Next state: synchronisers, registers, read data, sequencer
  // --------------------------------------------------------------------
  always_comb begin
    next_r          = r;
    next_r.s1       = {rst_pin_b, spi_select_pin, external_interrupt_pin};
    next_r.s2       = r.s1;
    next_r.ss_prev  = r.s2[1];
    next_r.pll_prev = pll_locked;
    // Set wins over clear
    next_r.flags    = (r.flags & ~clr_v) | set_v;
    next_r.pend     = 1'b0;
    next_r.cnt      = r.cnt;

    // Enable writes
    if (reg_wr && reg_addr == `RSIC_ADDR_EN_LO) begin
      next_r.en[7:0] = reg_wdata;
    end
    if (reg_wr && reg_addr == `RSIC_ADDR_EN_HI) begin
      next_r.en[10:8] = reg_wdata[2:0];
    end

    // Read data valid the cycle after the strobe
    next_r.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RSIC_ADDR_CAUSE:   next_r.rdata = cif.cause;
        `RSIC_ADDR_FLAG_LO: next_r.rdata = r.flags[7:0];
        `RSIC_ADDR_FLAG_HI: next_r.rdata = {5'h00, r.flags[10:8]};
        `RSIC_ADDR_EN_LO:   next_r.rdata = r.en[7:0];
        `RSIC_ADDR_EN_HI:   next_r.rdata = {5'h00, r.en[10:8]};
        `RSIC_ADDR_STATE:   next_r.rdata = {3'h0, cif.grp_any, r.st};
        default:            next_r.rdata = 8'h00;
      endcase
    end

    // Entry sequencer
    case (r.st)
      RSIC_IDLE: begin
        if (boundary) begin
          if (cpu_insn_done && cpu_swi_exec) begin
            // Unmaskable, PC itself is stacked
            next_r.st     = RSIC_STACK;
            next_r.vec    = `RSIC_VEC_SWI;
            next_r.pc_dec = 1'b0;
            next_r.cnt    = `RSIC_STACK_FIRST;
          end else if (cpu_insn_done && cpu_rti_exec) begin
            next_r.st  = RSIC_UNSTACK;
            next_r.cnt = `RSIC_STACK_FIRST;
          end else if (!cpu_i_mask && cif.grp_any) begin
            // Winner frozen here until the vector is loaded
            next_r.st     = RSIC_STACK;
            next_r.vec    = cif.grp_vec;
            next_r.pc_dec = 1'b1;
            next_r.cnt    = `RSIC_STACK_FIRST;
          end
        end
      end
      RSIC_STACK: begin
        // Five pushes, index high byte excluded
        if (r.cnt == `RSIC_STACK_LAST) begin
          next_r.st = RSIC_VECT;
        end else begin
          next_r.cnt = r.cnt + 3'h1;
        end
      end
      RSIC_VECT: begin
        next_r.st = RSIC_IDLE;
      end
      RSIC_UNSTACK: begin
        if (r.cnt == `RSIC_STACK_LAST) begin
          next_r.st   = RSIC_IDLE;
          next_r.pend = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 3'h1;
        end
      end
      default: begin
        next_r.st = RSIC_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r.st       <= RSIC_IDLE;
      r.cnt      <= 3'h0;
      r.pend     <= 1'b0;
      r.pc_dec   <= 1'b0;
      r.vec      <= 16'h0000;
      r.flags    <= 11'h000;
      r.en       <= 11'h001; // External pin masked after reset
      r.rdata    <= 8'h00;
      r.s1       <= 3'h7;
      r.s2       <= 3'h7;
      r.ss_prev  <= 1'b1;
      r.pll_prev <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign reg_rdata          = r.rdata;
  assign stack_push         = (r.st == RSIC_STACK);
  assign stack_pop          = (r.st == RSIC_UNSTACK);
  // Push order PCL..CCR, pop order reversed
  assign stack_sel          = stack_pop ? (`RSIC_STACK_LAST - r.cnt) : r.cnt;
  assign stack_pc_minus_one = r.pc_dec;
  assign vector_load        = (r.st == RSIC_VECT);
  assign vector_addr        = r.vec;
  assign set_i_mask         = (r.st == RSIC_VECT);
  assign cpu_hold           = (r.st != RSIC_IDLE) || r.pend;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_no_abort_entry: assert property (r.st == RSIC_IDLE && !boundary |=> r.st == RSIC_IDLE)
    else $error("entry started mid-instruction");
  a_push_five_bytes: assert property ($rose(stack_push) |-> stack_push [*5] ##1 !stack_push)
    else $error("push count is not five");
  a_vector_frozen: assert property (r.st == RSIC_STACK |=> $stable(vector_addr))
    else $error("latched vector changed");
  a_mask_on_vector: assert property ($fell(stack_push) |-> set_i_mask && vector_load)
    else $error("mask not set at vector load");
  a_sel_no_high: assert property (stack_push || stack_pop |-> stack_sel <= `RSIC_STACK_LAST)
    else $error("bad stack select");
  a_rti_recheck: assert property (r.st == RSIC_UNSTACK && r.cnt == `RSIC_STACK_LAST
                                  |=> r.pend && cpu_hold)
    else $error("no recheck after return");
  a_masked_blocks: assert property (r.st == RSIC_IDLE && boundary && cpu_i_mask &&
                                    !cpu_swi_exec && !cpu_rti_exec
                                    |=> r.st == RSIC_IDLE)
    else $error("masked request was taken");
  a_swi_pc_plain: assert property (r.st == RSIC_IDLE && cpu_insn_done && cpu_swi_exec
                                   |=> r.st == RSIC_STACK && !stack_pc_minus_one
                                   && vector_addr == `RSIC_VEC_SWI)
    else $error("software interrupt entry wrong");
  a_ext_latch: assert property (!r.s2[0] |=> r.flags[`RSIC_F_EXT])
    else $error("external request not latched");
  a_pll_change: assert property (pll_locked != r.pll_prev |=> r.flags[`RSIC_F_PLL])
    else $error("pll change flag missed");
  a_overflow_gate: assert property (!r.en[`RSIC_F_T1OV] |-> !cif.grp_req[5])
    else $error("ungated overflow request");
  a_overrun_set: assert property (spi_rx_xfer && r.flags[`RSIC_F_RX] && !spi_rx_read
                                  |=> r.flags[`RSIC_F_OVR])
    else $error("overrun flag missed");

  c_swi_entry: cover property (r.st == RSIC_IDLE && cpu_insn_done && cpu_swi_exec);
  c_hw_entry:  cover property (r.st == RSIC_STACK && stack_pc_minus_one ##5 vector_load);
  c_rti_then_take: cover property (r.pend && !cpu_i_mask && cif.grp_any);
  c_cause_read: cover property (cif.cause_rd && cif.cause != 8'h00);

endmodule : rsic_top
`default_nettype wire

// ---- pkg/rsic_if.sv ----
// Purpose: Carrier between the core and its cause and priority blocks
// Assumes: Single clock domain
// Notes:   Cause sources are levels held during a reset
`default_nettype none

interface rsic_if;
  logic [6:1]  cause_src;
  logic        cause_rd;
  logic [7:0]  cause;
  logic [16:1] grp_req;
  logic        grp_any;
  logic [15:0] grp_vec;

  modport core  (output cause_src, cause_rd, grp_req, input cause, grp_any, grp_vec);
  modport cause_side (input cause_src, cause_rd, output cause);
  modport prio  (input grp_req, output grp_any, grp_vec);
endinterface : rsic_if

`default_nettype wire

// ---- pkg/rsic_params.svh ----
// Purpose: Named constants of the reset status and interrupt controller
// Assumes: Included by its bare name from the package and the design files
// Notes:   Definitions only
`ifndef RSIC_PARAMS_SVH
`define RSIC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define RSIC_ADDR_CAUSE   3'h0
`define RSIC_ADDR_FLAG_LO 3'h1
`define RSIC_ADDR_FLAG_HI 3'h2
`define RSIC_ADDR_EN_LO   3'h3
`define RSIC_ADDR_EN_HI   3'h4
`define RSIC_ADDR_STATE   3'h5

// ----------------------------------------------------------------------
// Reset cause bits and power-on value
// ----------------------------------------------------------------------
`define RSIC_CAUSE_POR_VAL 8'h80
`define RSIC_CAUSE_PIN     6
`define RSIC_CAUSE_LOWV    1

// ----------------------------------------------------------------------
// Source flag indices (enable bits at the same positions, but bit 0 masks and bit 9 enables fault detection; bit 8 gates flag 9)
// ----------------------------------------------------------------------
`define RSIC_F_EXT   0
`define RSIC_F_PLL   1
`define RSIC_F_T1OV  4
`define RSIC_F_RX    7
`define RSIC_F_OVR   8
`define RSIC_F_FAULT 9
`define RSIC_E_FDEN  9
`define RSIC_NFLAG   11

// ----------------------------------------------------------------------
// Stacking: PCL, PCH, X, A, CCR; index high byte is never stacked
// ----------------------------------------------------------------------
`define RSIC_STACK_FIRST 3'h0
`define RSIC_STACK_LAST  3'h4

// ----------------------------------------------------------------------
// Vector addresses per priority group
// ----------------------------------------------------------------------
`define RSIC_VEC_SWI 16'hfffc
`define RSIC_VEC_G1  16'hfffa
`define RSIC_VEC_G2  16'hfff8
`define RSIC_VEC_G3  16'hfff6
`define RSIC_VEC_G4  16'hfff4
`define RSIC_VEC_G5  16'hfff2
`define RSIC_VEC_G6  16'hfff0
`define RSIC_VEC_G8  16'hffec
`define RSIC_VEC_G9  16'hffea
`define RSIC_VEC_G10 16'hffe8
`define RSIC_VEC_G11 16'hffe6
`define RSIC_VEC_G12 16'hffe4
`define RSIC_VEC_G13 16'hffe2
`define RSIC_VEC_G14 16'hffde
`define RSIC_VEC_G15 16'hffde
`define RSIC_VEC_G16 16'hffdc

`endif

// ---- pkg/rsic_pkg.sv ----
// Purpose: Types of the reset status and interrupt controller
// Assumes: rsic_params.svh supplies the widths
// Notes:   One-hot sequencer states
`default_nettype none
`include "rsic_params.svh"

package rsic_pkg;

  // --------------------------------------------------------------------
  // Entry sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    RSIC_IDLE    = 4'b0001,
    RSIC_STACK   = 4'b0010,
    RSIC_VECT    = 4'b0100,
    RSIC_UNSTACK = 4'b1000
  } rsic_state_t;

  // Core state
  typedef struct packed {
    rsic_state_t               st;
    logic [2:0]                cnt;
    logic                      pend;
    logic                      pc_dec;
    logic [15:0]               vec;
    logic [`RSIC_NFLAG-1:0]    flags;
    logic [`RSIC_NFLAG-1:0]    en;
    logic [7:0]                rdata;
    logic [2:0]                s1;
    logic [2:0]                s2;
    logic                      ss_prev;
    logic                      pll_prev;
  } rsic_core_t;

  // Reset cause state
  typedef struct packed {
    logic [7:0] cause;
  } rsic_cause_t;

endpackage : rsic_pkg
`default_nettype wire

// ---- tb/rsic_cpu_model.sv ----
// Purpose: CPU core stand-in that issues boundaries and tracks the I bit
// Assumes: The bench asks for each boundary with go
// Notes:   CCR pop restores the I bit clear
`default_nettype none
module rsic_cpu_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Bench commands
  input  wire logic go,
  input  wire logic software_interrupt,
  input  wire logic return_from_interrupt,
  // Controller side
  input  wire logic set_i_mask,
  input  wire logic cpu_hold,
  input  wire logic busy,
  input  wire logic pop,
  output logic      insn_done,
  output logic      i_mask,
  output logic      swi_exec,
  output logic      rti_exec
);
  timeunit 1ns;
  timeprecision 1ps;
  // Boundary pulse, qualifiers and I bit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {insn_done, i_mask, swi_exec, rti_exec} <= 4'h0;
    end else begin
      insn_done <= go & ~cpu_hold & ~busy;
      swi_exec  <= software_interrupt;
      rti_exec  <= return_from_interrupt;
      if (set_i_mask) i_mask <= 1'b1;
      else if (pop) i_mask <= 1'b0;
    end
  end
endmodule : rsic_cpu_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench of the reset cause and interrupt block
// Assumes: Register offsets and vectors from rsic_params.svh
// Notes:   Pending groups kept in a queue, lowest number wins
`default_nettype none
`include "rsic_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_b, reg_wr, reg_rd, go, software_interrupt, return_from_interrupt, rst_pin_b, pll, t1w, t2w, t2c;
  logic srx, stx, srd, smst, sbusy, ssel, ext_n, push, pop, pcm1, vload, setm, hold;
  logic done, imask, swix, rtix;
  logic [1:0]  t1c;
  logic [2:0]  addr, sel;
  logic [5:1]  src;
  logic [5:0]  egrp;
  logic [7:0]  wdata, rdata;
  logic [15:0] vaddr;
  int          n_errors, n_tests;
  int          pend[$];
  wire         busy = push | pop;
  // ----------------------------------------------------------------
  // Design and CPU model
  // ----------------------------------------------------------------
  rsic_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .rst_pin_b(rst_pin_b),
    .rst_src_wdog(src[5]), .rst_src_opcode(src[4]), .rst_src_fetch(src[3]),
    .rst_src_monitor(src[2]), .rst_src_lowv(src[1]), .cpu_insn_done(done),
    .cpu_i_mask(imask), .cpu_swi_exec(swix), .cpu_rti_exec(rtix), .stack_push(push),
    .stack_pop(pop), .stack_sel(sel), .stack_pc_minus_one(pcm1), .vector_load(vload),
    .vector_addr(vaddr), .set_i_mask(setm), .cpu_hold(hold), .external_interrupt_pin(ext_n),
    .pll_locked(pll), .tim1_wrap(t1w), .tim1_chan_evt(t1c), .tim2_wrap(t2w),
    .tim2_chan_evt(t2c), .spi_rx_xfer(srx), .spi_tx_xfer(stx), .spi_rx_read(srd),
    .spi_master(smst), .spi_busy(sbusy), .spi_select_pin(ssel), .ext_grp_req(egrp));
  rsic_cpu_model cpu_u (.sys_clk(sys_clk), .rst_b(rst_b), .go(go), .software_interrupt(software_interrupt), .return_from_interrupt(return_from_interrupt),
    .set_i_mask(setm), .cpu_hold(hold), .busy(busy), .pop(pop), .insn_done(done),
    .i_mask(imask), .swi_exec(swix), .rti_exec(rtix));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr   <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rd
  // Expected vector of the best pending group
  function automatic logic [15:0] best();
    int q[$];
    q = pend.min();
    return 16'hfffc - 16'(2 * q[0]);
  endfunction : best
  // One boundary; v of zero means no entry may follow
  task automatic take(input logic s, input logic r, input logic [15:0] v, input logic m);
    int k;
    int np;
    k  = 0;
    np = 0;
    @(posedge sys_clk);
    go  <= 1'b1;
    software_interrupt <= s;
    return_from_interrupt <= r;
    @(posedge sys_clk);
    {go, software_interrupt, return_from_interrupt} <= 3'b000;
    while (vload !== 1'b1 && k < 40) begin
      @(posedge sys_clk);
      #1;
      if (push === 1'b1) chk({13'h0000, sel}, 16'(np));
      if (pop === 1'b1) chk({13'h0000, sel}, 16'(4 - k));
      np += int'(push === 1'b1);
      k++;
    end
    chk((vload === 1'b1) ? vaddr : 16'h0000, v);
    chk(16'(np), (v == 16'h0000) ? 16'h0000 : 16'h0005);
    if (v != 16'h0000) chk({15'h0000, pcm1}, {15'h0000, m});
    chk({15'h0000, setm}, {15'h0000, v != 16'h0000});
  endtask : take
  task automatic print_verdict();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    {rst_b, reg_wr, reg_rd, go, software_interrupt, return_from_interrupt, pll, t1w, t2w, t2c, srx, stx, srd} = '0;
    {smst, sbusy, addr, wdata, src, t1c, egrp} = '0;
    {rst_pin_b, ext_n, ssel} = 3'b111;
    n_errors = 0;
    n_tests  = 0;
    void'($urandom(32'hcba7));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(`RSIC_ADDR_CAUSE, 8'h80);
    rd(`RSIC_ADDR_CAUSE, 8'h00);
    // Every later reset source, then the pin
    for (int i = 1; i <= 5; i++) begin
      @(posedge sys_clk) src <= 5'(1 << (i - 1));
    end
    @(posedge sys_clk) src <= 5'h00;
    rst_pin_b <= 1'b0;
    @(posedge sys_clk) rst_pin_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`RSIC_ADDR_CAUSE, 8'h7e);
    rd(`RSIC_ADDR_CAUSE, 8'h00);
    // Random events with their enables off raise no request
    repeat (8) @(posedge sys_clk) {t1c, t2w, t2c, srx, stx, ext_n} <= 7'($urandom);
    @(posedge sys_clk) {t1c, t2w, t2c, srx, stx, ext_n} <= 7'h01;
    repeat (4) @(posedge sys_clk);
    rd(`RSIC_ADDR_STATE, 8'h01);
    wr(3'h6, 8'($urandom));
    rd(3'h6, 8'h00);
    wr(`RSIC_ADDR_FLAG_LO, 8'hff);
    wr(`RSIC_ADDR_FLAG_HI, 8'h07);
    wr(`RSIC_ADDR_EN_LO, 8'h13);
    // Timer wrap, then PLL change under the mask, then software entry
    @(posedge sys_clk) t1w <= 1'b1;
    @(posedge sys_clk) t1w <= 1'b0;
    pend.push_back(5);
    take(1'b0, 1'b0, best(), 1'b1);
    @(posedge sys_clk) pll <= 1'b1;
    pend.push_back(2);
    repeat (2) @(posedge sys_clk);
    take(1'b0, 1'b0, 16'h0000, 1'b1);
    take(1'b1, 1'b0, `RSIC_VEC_SWI, 1'b0);
    take(1'b0, 1'b1, best(), 1'b1);
    // Outside group request alone, taken on the recheck after a return
    wr(`RSIC_ADDR_FLAG_LO, 8'hff);
    pend.delete();
    @(posedge sys_clk) egrp <= 6'h20;
    pend.push_back(16);
    take(1'b0, 1'b1, best(), 1'b1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
